// [logic/icu_pkg.sv]
// constants, modes and carrier structs of the input capture unit
// assumes one 100 MHz clock, synchronous active-high reset
//
// Summary of operation
// R1 - qualifying event stores selected 16-bit timebase count
// R2 - simple modes capture on falling or rising
// R3 - both-edges mode captures on every transition
// R4 - prescaled modes capture every 4th/16th rise
// R5 - each channel selects timebase a or b
// R6 - timebases count internal clock or external clock
// R7 - up to three independent capture channels
// R8 - capture event wakes cpu from sleep/idle
// R9 - capture events can raise channel interrupt
// R10 - four-entry fifo per channel, read in order
// R11 - interrupt after 1, 2, 3 or 4 entries
// R12 - channel usable as plain external interrupt
// R13 - full fifo drops capture, sticky overflow flag
// R14 - status shows unread capture value present
package icu_pkg;

	// -----------------------------------------------------------------
	// sizes
	// -----------------------------------------------------------------
	localparam int DW         = 16;
	localparam int AW         = 8;
	localparam int MAX_CH     = 3;
	localparam int FIFO_DEPTH = 4;
	localparam int PRE4       = 4;
	localparam int PRE16      = 16;

	// -----------------------------------------------------------------
	// register offsets (word index on the plain port)
	// -----------------------------------------------------------------
	localparam logic [AW-1:0] OFF_TMR_CTRL = 8'h00;
	localparam logic [AW-1:0] OFF_TMR_A    = 8'h01;
	localparam logic [AW-1:0] OFF_TMR_B    = 8'h02;
	localparam logic [AW-1:0] OFF_INT_STAT = 8'h03;
	localparam logic [AW-1:0] OFF_INT_MASK = 8'h04;
	localparam logic [AW-1:0] OFF_CH_BASE  = 8'h10;
	localparam logic [AW-1:0] CH_STRIDE    = 8'h04;
	localparam logic [AW-1:0] CH_CTRL      = 8'h00;
	localparam logic [AW-1:0] CH_BUF       = 8'h01;
	localparam logic [AW-1:0] CH_STAT      = 8'h02;

	// interrupt status bit positions, one bit per channel from each
	localparam int INT_LVL_POS = 0;
	localparam int INT_OVF_POS = 4;
	localparam int INT_EXT_POS = 8;

	// reset values
	localparam logic [3:0]    TMR_CTRL_RST = 4'h0;
	localparam logic [DW-1:0] TMR_RST      = 16'h0000;
	localparam logic [DW-1:0] INT_RST      = 16'h0000;
	localparam logic [5:0]    CH_CTRL_RST  = 6'h00;

	// -----------------------------------------------------------------
	// types
	// -----------------------------------------------------------------
	typedef enum logic [2:0] {
		ICU_MODE_OFF    = 3'h0,
		ICU_MODE_BOTH   = 3'h1,
		ICU_MODE_FALL   = 3'h2,
		ICU_MODE_RISE   = 3'h3,
		ICU_MODE_RISE4  = 3'h4,
		ICU_MODE_RISE16 = 3'h5,
		ICU_MODE_EXTINT = 3'h7
	} icu_mode_e;

	typedef struct packed {
		logic [1:0] lvl;      // entries before interrupt, minus one
		logic       tsel;     // 0 timebase_a, 1 timebase_b
		icu_mode_e  mode;
	} icu_ch_cfg_s;

	typedef struct packed {
		logic b_ext;
		logic b_en;
		logic a_ext;
		logic a_en;
	} icu_tmr_cfg_s;

	typedef struct packed {
		logic cap;            // take a capture this cycle
		logic ext;            // plain external interrupt event
	} icu_evt_s;

endpackage

// [logic/icu_evt.sv]
// edge qualifier and prescaler of one capture channel
// assumes the pin is synchronous to clk
`timescale 1ns/10ps
module icu_evt
(
	input  wire logic              clk,   // system clock
	input  wire logic              rst,   // sync reset
	input  wire logic              pin,   // capture input
	input  icu_pkg::icu_mode_e     mode,  // channel mode
	output icu_pkg::icu_evt_s      evt    // qualified events
);

	typedef struct packed {
		logic       prev;
		logic [3:0] pre;
	} icu_evt_st_s;

	icu_evt_st_s s_q;
	icu_evt_st_s s_d;
	logic        rise;
	logic        fall;

	// edge detect against last sample
	assign rise = pin & ~s_q.prev;
	assign fall = ~pin & s_q.prev;

	// next state and qualified events
	always_comb
	begin
		s_d      = s_q;
		s_d.prev = pin;
		evt      = '0;
		case (mode)
			// R3 every edge
			icu_pkg::ICU_MODE_BOTH:   evt.cap = rise | fall;
			// R2 falling only
			icu_pkg::ICU_MODE_FALL:   evt.cap = fall;
			// R2 rising only
			icu_pkg::ICU_MODE_RISE:   evt.cap = rise;
			// R4 every 4th rise
			icu_pkg::ICU_MODE_RISE4:
			begin
				if (rise)
					s_d.pre = (s_q.pre == 4'(icu_pkg::PRE4 - 1)) ? 4'h0 : s_q.pre + 4'h1;
				evt.cap = rise && (s_q.pre == 4'(icu_pkg::PRE4 - 1));
			end
			// R4 every 16th rise
			icu_pkg::ICU_MODE_RISE16:
			begin
				if (rise)
					s_d.pre = s_q.pre + 4'h1;
				evt.cap = rise && (s_q.pre == 4'(icu_pkg::PRE16 - 1));
			end
			// R12 rising edges only interrupt
			icu_pkg::ICU_MODE_EXTINT: evt.ext = rise;
			default:                  evt = '0;
		endcase
		// prescaler restarts outside the prescaled modes
		if (mode != icu_pkg::ICU_MODE_RISE4 && mode != icu_pkg::ICU_MODE_RISE16)
			s_d.pre = 4'h0;
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

endmodule

// [logic/icu_fifo.sv]
// capture fifo with sticky overflow, push dropped when full and not popped in the same cycle
// assumes pop only matters when not empty
`timescale 1ns/10ps
module icu_fifo
#(
	parameter int W     = 16,
	parameter int DEPTH = 4
)
(
	input  wire logic                       clk,      // system clock
	input  wire logic                       rst,      // sync reset
	input  wire logic                       push,     // store request
	input  wire logic [W-1:0]               wdat,     // value to store
	input  wire logic                       pop,      // drop head
	output logic      [W-1:0]               head,     // oldest entry
	output logic      [$clog2(DEPTH+1)-1:0] count,    // entries held
	output logic      [$clog2(DEPTH+1)-1:0] count_nx, // count after this cycle
	output logic                            push_ok,  // push accepted
	output logic                            ovf       // overflow flag
);

	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	if (DEPTH < 2 || (1 << PW) != DEPTH)
		$error("icu_fifo depth must be a power of two");

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0]           wp;
		logic [PW-1:0]           rp;
		logic [CW-1:0]           cnt;
		logic                    ovf;
	} icu_fifo_st_s;

	icu_fifo_st_s s_q;
	icu_fifo_st_s s_d;
	logic         do_pop;

	// pointer and count update
	always_comb
	begin
		s_d     = s_q;
		do_pop  = pop && (s_q.cnt != '0);
		push_ok = push && (s_q.cnt != CW'(DEPTH) || do_pop);
		if (push_ok)
		begin
			s_d.mem[s_q.wp] = wdat;
			s_d.wp          = s_q.wp + PW'(1);
		end
		if (do_pop)
			s_d.rp = s_q.rp + PW'(1);
		s_d.cnt = s_q.cnt + CW'(push_ok) - CW'(do_pop);
		// R13 read clears, drop sets, set wins
		if (pop)
			s_d.ovf = 1'b0;
		if (push && !push_ok)
			s_d.ovf = 1'b1;
	end

	// R10 oldest value first
	assign head     = s_q.mem[s_q.rp];
	assign count    = s_q.cnt;
	assign count_nx = s_d.cnt;
	assign ovf      = s_q.ovf;

	// state register
	always_ff @(posedge clk)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

endmodule

// [logic/icu_top.sv]
// input capture unit: two timebases, up to three capture channels,
// register port, interrupt and wake-up outputs
// assumes all inputs synchronous to clk and a clock that keeps
// running while the cpu sleeps or idles
`timescale 1ns/10ps
module icu_top
#(
	parameter int NCH = icu_pkg::MAX_CH
)
(
	input  wire logic                       clk,                // 100 MHz clock
	input  wire logic                       rst,                // sync reset
	input  wire logic [icu_pkg::AW-1:0]     addr,               // register index
	input  wire logic [icu_pkg::DW-1:0]     wdata,              // write data
	input  wire logic                       wr_en,              // write strobe
	input  wire logic                       rd_en,              // read strobe
	output logic      [icu_pkg::DW-1:0]     rdata,              // read data, next cycle
	input  wire logic [NCH-1:0]             capture_input_pin,  // one per channel
	input  wire logic                       timebase_a_ext_clk, // external count a
	input  wire logic                       timebase_b_ext_clk, // external count b
	input  wire logic                       cpu_sleep,          // cpu in sleep
	input  wire logic                       cpu_idle,           // cpu in idle
	output logic                            irq,                // level interrupt
	output logic                            wake_req            // wake-up pulse
);

	localparam int DW = icu_pkg::DW;
	localparam int AW = icu_pkg::AW;
	localparam int CW = $clog2(icu_pkg::FIFO_DEPTH + 1);

	// -----------------------------------------------------------------
	// elaboration checks
	// -----------------------------------------------------------------

	// R7 at most three channels
	if (NCH < 1 || NCH > icu_pkg::MAX_CH)
		$error("icu_top channel count out of range");

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------

	typedef struct packed {
		logic [DW-1:0]                   tmr_a;
		logic [DW-1:0]                   tmr_b;
		icu_pkg::icu_tmr_cfg_s           tcfg;
		logic                            ext_a_prev;
		logic                            ext_b_prev;
		logic [DW-1:0]                   stat;
		logic [DW-1:0]                   mask;
		icu_pkg::icu_ch_cfg_s [NCH-1:0]  ch_cfg;
		logic [DW-1:0]                   rdata;
		logic                            irq;
		logic                            wake;
	} icu_top_st_s;

	icu_top_st_s s_q;
	icu_top_st_s s_d;

	// per-channel wiring
	icu_pkg::icu_evt_s     evt      [NCH];
	logic [DW-1:0]         cap_val  [NCH];
	logic [DW-1:0]         head     [NCH];
	logic [CW-1:0]         cnt      [NCH];
	logic [CW-1:0]         cnt_nx   [NCH];
	logic [NCH-1:0]        push_ok;
	logic [NCH-1:0]        ovf;
	logic [NCH-1:0]        pop;
	logic [NCH-1:0]        dropped;

	// -----------------------------------------------------------------
	// channels
	// -----------------------------------------------------------------

	for (genvar c = 0; c < NCH; c++)
	begin : g_ch

		// event qualification for this channel
		icu_evt u_evt
		(
			.clk  (clk),
			.rst  (rst),
			.pin  (capture_input_pin[c]),
			.mode (s_q.ch_cfg[c].mode),
			.evt  (evt[c])
		);

		// R5 sample only the selected timebase
		assign cap_val[c] = s_q.ch_cfg[c].tsel ? s_q.tmr_b : s_q.tmr_a;

		// R1 R10 capture value into channel fifo
		icu_fifo
		#(
			.W     (DW),
			.DEPTH (icu_pkg::FIFO_DEPTH)
		)
		u_fifo
		(
			.clk      (clk),
			.rst      (rst),
			.push     (evt[c].cap),
			.wdat     (cap_val[c]),
			.pop      (pop[c]),
			.head     (head[c]),
			.count    (cnt[c]),
			.count_nx (cnt_nx[c]),
			.push_ok  (push_ok[c]),
			.ovf      (ovf[c])
		);

		// a capture that the full fifo refused
		assign dropped[c] = evt[c].cap & ~push_ok[c];
	end

	// -----------------------------------------------------------------
	// address decode helpers
	// -----------------------------------------------------------------

	function automatic logic [AW-1:0] ch_addr(input int c, input logic [AW-1:0] reg_off);
		ch_addr = AW'(icu_pkg::OFF_CH_BASE + AW'(c) * icu_pkg::CH_STRIDE + reg_off);
	endfunction

	// buffer reads pop the head entry
	always_comb
	begin
		for (int c = 0; c < NCH; c++)
			pop[c] = rd_en && (addr == ch_addr(c, icu_pkg::CH_BUF));
	end

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------

	logic [DW-1:0] set_bits;
	logic [DW-1:0] rd_val;
	logic          any_evt;

	always_comb
	begin
		s_d      = s_q;
		set_bits = '0;
		rd_val   = '0;
		any_evt  = 1'b0;

		// R6 timebase a on internal or external clock
		s_d.ext_a_prev = timebase_a_ext_clk;
		if (s_q.tcfg.a_en)
		begin
			if (!s_q.tcfg.a_ext)
				s_d.tmr_a = s_q.tmr_a + 16'h0001;
			else if (timebase_a_ext_clk && !s_q.ext_a_prev)
				s_d.tmr_a = s_q.tmr_a + 16'h0001;
		end

		// R6 timebase b on internal or external clock
		s_d.ext_b_prev = timebase_b_ext_clk;
		if (s_q.tcfg.b_en)
		begin
			if (!s_q.tcfg.b_ext)
				s_d.tmr_b = s_q.tmr_b + 16'h0001;
			else if (timebase_b_ext_clk && !s_q.ext_b_prev)
				s_d.tmr_b = s_q.tmr_b + 16'h0001;
		end

		// channel events into sticky status bits
		for (int c = 0; c < NCH; c++)
		begin
			// R9 R11 interrupt when fill level reached
			if (push_ok[c] && cnt_nx[c] == CW'({1'b0, s_q.ch_cfg[c].lvl} + 3'h1))
				set_bits[icu_pkg::INT_LVL_POS + c] = 1'b1;
			// R13 refused capture flags overflow
			if (dropped[c])
				set_bits[icu_pkg::INT_OVF_POS + c] = 1'b1;
			// R12 plain external interrupt
			if (evt[c].ext)
				set_bits[icu_pkg::INT_EXT_POS + c] = 1'b1;
			any_evt = any_evt | evt[c].cap | evt[c].ext;
		end

		// register writes
		if (wr_en)
		begin
			case (addr)
				icu_pkg::OFF_TMR_CTRL: s_d.tcfg  = icu_pkg::icu_tmr_cfg_s'(wdata[3:0]);
				icu_pkg::OFF_TMR_A:    s_d.tmr_a = wdata;
				icu_pkg::OFF_TMR_B:    s_d.tmr_b = wdata;
				icu_pkg::OFF_INT_MASK: s_d.mask  = wdata;
				default:               s_d.mask  = s_d.mask;
			endcase
			for (int c = 0; c < NCH; c++)
			begin
				if (addr == ch_addr(c, icu_pkg::CH_CTRL))
					s_d.ch_cfg[c] = icu_pkg::icu_ch_cfg_s'(wdata[5:0]);
			end
		end

		// read mux, unmapped indices read zero
		case (addr)
			icu_pkg::OFF_TMR_CTRL: rd_val = {12'h000, s_q.tcfg};
			icu_pkg::OFF_TMR_A:    rd_val = s_q.tmr_a;
			icu_pkg::OFF_TMR_B:    rd_val = s_q.tmr_b;
			icu_pkg::OFF_INT_STAT: rd_val = s_q.stat;
			icu_pkg::OFF_INT_MASK: rd_val = s_q.mask;
			default:               rd_val = '0;
		endcase
		for (int c = 0; c < NCH; c++)
		begin
			if (addr == ch_addr(c, icu_pkg::CH_CTRL))
				rd_val = {10'h000, s_q.ch_cfg[c]};
			// R10 head entry, popped by this read
			if (addr == ch_addr(c, icu_pkg::CH_BUF))
				rd_val = head[c];
			// R14 not-empty, overflow and fill level
			if (addr == ch_addr(c, icu_pkg::CH_STAT))
				rd_val = {11'h000, cnt[c], ovf[c], (cnt[c] != '0)};
		end
		s_d.rdata = rd_en ? rd_val : '0;

		// status: read clears, a new event in that cycle survives
		if (rd_en && addr == icu_pkg::OFF_INT_STAT)
			s_d.stat = '0;
		s_d.stat = s_d.stat | set_bits;

		// level interrupt from unmasked sticky bits
		s_d.irq = |(s_d.stat & s_d.mask);

		// R8 capture input wakes a sleeping or idle cpu
		s_d.wake = any_evt && (cpu_sleep || cpu_idle);
	end

	// -----------------------------------------------------------------
	// state register
	// -----------------------------------------------------------------

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_q.tmr_a      <= icu_pkg::TMR_RST;
			s_q.tmr_b      <= icu_pkg::TMR_RST;
			s_q.tcfg       <= icu_pkg::icu_tmr_cfg_s'(icu_pkg::TMR_CTRL_RST);
			s_q.ext_a_prev <= 1'b0;
			s_q.ext_b_prev <= 1'b0;
			s_q.stat       <= icu_pkg::INT_RST;
			s_q.mask       <= icu_pkg::INT_RST;
			s_q.ch_cfg     <= {NCH{icu_pkg::icu_ch_cfg_s'(icu_pkg::CH_CTRL_RST)}};
			s_q.rdata      <= '0;
			s_q.irq        <= 1'b0;
			s_q.wake       <= 1'b0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// -----------------------------------------------------------------
	// outputs, all from flops
	// -----------------------------------------------------------------

	assign rdata    = s_q.rdata;
	assign irq      = s_q.irq;
	assign wake_req = s_q.wake;

endmodule

// [test/icu_top_sva.sv]
// concurrent checks on the ports of the input capture unit
// assumes bound to icu_top, one clock, synchronous active-high reset
`timescale 1ns/10ps
module icu_top_sva
#(
	parameter int NCH = 3
)
(
	input wire logic                   clk,               // clock
	input wire logic                   rst,               // sync reset
	input wire logic [icu_pkg::AW-1:0] addr,              // register index
	input wire logic [icu_pkg::DW-1:0] wdata,             // write data
	input wire logic                   wr_en,             // write strobe
	input wire logic                   rd_en,             // read strobe
	input wire logic [icu_pkg::DW-1:0] rdata,             // read data
	input wire logic [NCH-1:0]         capture_input_pin, // capture inputs
	input wire logic                   cpu_sleep,         // cpu sleeping
	input wire logic                   cpu_idle,          // cpu idle
	input wire logic                   irq,               // interrupt
	input wire logic                   wake_req           // wake pulse
);
	logic [3:0] tctrl_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// shadow of the timebase control register
	always_ff @(posedge clk)
	begin
		if (rst)
			tctrl_q <= 4'h0;
		else if (wr_en && addr == icu_pkg::OFF_TMR_CTRL)
			tctrl_q <= wdata[3:0];
	end

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	rdata_idle_a: assert property (!rd_en |=> rdata == 16'h0000)
		else $error("read data not zero outside read reply");
	rdata_unmapped_a: assert property (rd_en && addr >= 8'h20 |=> rdata == 16'h0000)
		else $error("unmapped read returned data");
	wake_gate_a: assert property (!(cpu_sleep || cpu_idle) |=> !wake_req)
		else $error("wake while cpu running");
	wake_cause_a: assert property ($stable(capture_input_pin) |=> !wake_req)
		else $error("wake without pin transition");
	irq_cause_a: assert property ($rose(irq) |->
		$past(capture_input_pin) != $past(capture_input_pin, 2) || $past(wr_en))
		else $error("interrupt rose without cause");
	irq_clear_a: assert property (rd_en && addr == icu_pkg::OFF_INT_STAT &&
		$stable(capture_input_pin) |=> !irq)
		else $error("interrupt kept after status read");
	irq_sticky_a: assert property (irq && !rd_en && !wr_en |=> irq)
		else $error("interrupt dropped by itself");
	tmr_hold_a: assert property (wr_en && addr == icu_pkg::OFF_TMR_A ##1 rd_en &&
		addr == icu_pkg::OFF_TMR_A && !tctrl_q[0] |=> rdata == $past(wdata, 2))
		else $error("stopped timebase lost written value");
	tmr_count_a: assert property (rd_en && addr == icu_pkg::OFF_TMR_A && !wr_en &&
		tctrl_q[1:0] == 2'b01 ##1 rd_en && addr == icu_pkg::OFF_TMR_A && !wr_en
		|=> rdata == $past(rdata) + 16'h0001)
		else $error("timebase did not count one per clock");

	cover property (wake_req);
	cover property ($rose(irq));
	cover property (rd_en && addr == 8'h11);
endmodule

bind icu_top icu_top_sva #(.NCH(NCH)) u_sva (.clk, .rst, .addr, .wdata, .wr_en, .rd_en,
	.rdata, .capture_input_pin, .cpu_sleep, .cpu_idle, .irq, .wake_req);

// [test/icu_sig_src.sv]
// external pulse source feeding the capture pins
// assumes start is a one-cycle request, pins idle low between bursts
`timescale 1ns/10ps
module icu_sig_src
#(
	parameter int NCH  = 3,
	parameter int HALF = 3
)
(
	input  wire logic           clk,    // clock
	input  wire logic           rst,    // sync reset
	input  wire logic           start,  // begin a burst
	input  wire logic [1:0]     ch,     // pin to drive
	input  wire logic [4:0]     npulse, // full pulses in burst
	output logic      [NCH-1:0] pin,    // capture pins
	output logic                busy    // burst in progress
);
	logic [5:0] left_q;
	logic [3:0] gap_q;
	logic [1:0] sel_q;

	// toggle the chosen pin every HALF+1 cycles, ending low
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pin    <= '0;
			left_q <= 6'h00;
			gap_q  <= 4'h0;
			sel_q  <= 2'h0;
		end
		else if (start)
		begin
			left_q <= {npulse, 1'b0};
			gap_q  <= 4'(HALF);
			sel_q  <= ch;
		end
		else if (left_q != 6'h00)
		begin
			if (gap_q == 4'h0)
			begin
				pin[sel_q] <= ~pin[sel_q];
				left_q     <= left_q - 6'h01;
				gap_q      <= 4'(HALF);
			end
			else
				gap_q <= gap_q - 4'h1;
		end
	end

	assign busy = (left_q != 6'h00);
endmodule

// [test/tb_top.sv]
// self-checking bench of the input capture unit with a queue model
// assumes icu_top, icu_sig_src and the bound checker are compiled first
`timescale 1ns/10ps
module tb_top;
	localparam int NCH = 3;
	localparam logic [7:0] RADR [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h10, 8'h12};
	localparam icu_pkg::icu_mode_e MODES [7] = '{icu_pkg::ICU_MODE_OFF,
		icu_pkg::ICU_MODE_BOTH, icu_pkg::ICU_MODE_FALL, icu_pkg::ICU_MODE_RISE,
		icu_pkg::ICU_MODE_RISE4, icu_pkg::ICU_MODE_RISE16, icu_pkg::ICU_MODE_EXTINT};
	logic               clk, rst, wr_en, rd_en, ext_clk, cpu_sleep, cpu_idle;
	logic               irq, wake_req, src_go, src_busy, last_wr, tsel, ovf;
	logic [7:0]         addr, base;
	logic [15:0]        wdata, rdata, lfsr_q, v, r, tmr_a, tmr_b, mask, st;
	logic [NCH-1:0]     pins;
	logic [1:0]         src_ch, lvl;
	logic [4:0]         src_n;
	icu_pkg::icu_mode_e m;
	int                 fails, tests_run, wakes, n, ncap, ch, kx, w;
	logic [15:0]        exp_q [$];

	icu_top #(.NCH(NCH)) DUT (.clk, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata,
		.capture_input_pin(pins), .timebase_a_ext_clk(ext_clk | (|pins)),
		.timebase_b_ext_clk(ext_clk), .cpu_sleep, .cpu_idle, .irq, .wake_req);
	icu_sig_src #(.NCH(NCH)) u_src (.clk, .rst, .start(src_go), .ch(src_ch),
		.npulse(src_n), .pin(pins), .busy(src_busy));

	// clock and wake pulse counter
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
		if (wake_req === 1'b1)
			wakes++;

	// -----------------------------------------------------------------
	// tasks
	// -----------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		if (last_wr)
			@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en   <= 1'b0;
		last_wr = 1'b1;
	endtask
	task automatic rc(input string what, input logic [7:0] a, input logic [15:0] e);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		@(posedge clk);
		last_wr = 1'b0;
		chk(what, rdata, e);
	endtask
	function automatic logic [15:0] rnd();
		lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
		return lfsr_q;
	endfunction
	task automatic print_verdict;
		$display("checks run %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// watchdog against a hung run
	initial
	begin
		repeat (20000) @(posedge clk);
		fails++;
		print_verdict();
	end

	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial
	begin
		{rst, wr_en, rd_en, ext_clk, cpu_sleep, cpu_idle, src_go, last_wr} = 8'h80;
		{addr, wdata, src_ch, src_n} = '0;
		lfsr_q    = 16'h0040;
		fails     = 0;
		tests_run = 0;
		wakes     = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		foreach (RADR[i])
			rc("reset value", RADR[i], 16'h0000);
		wr(icu_pkg::OFF_TMR_A, 16'h1234);
		rc("timer a hold", icu_pkg::OFF_TMR_A, 16'h1234);
		wr(icu_pkg::OFF_TMR_CTRL, 16'h0001);
		addr  <= icu_pkg::OFF_TMR_A;
		rd_en <= 1'b1;
		repeat (2) @(posedge clk);
		rd_en <= 1'b0;
		v = rdata;
		@(posedge clk);
		chk("timer a count", rdata, v + 16'h0001);
		wr(8'h30, 16'hFFFF);
		rc("unmapped", 8'h30, 16'h0000);
		wr(icu_pkg::OFF_TMR_CTRL, 16'h000F);
		for (int k = 0; k < 14; k++)
		begin
			m  = MODES[k % 7];
			ch = (k / 2) % 3;
			r = rnd();
			{lvl, tsel} = r[2:0];
			cpu_sleep <= r[3];
			cpu_idle  <= r[4] & r[5];
			n  = (m == icu_pkg::ICU_MODE_RISE4) ? 9 : (m == icu_pkg::ICU_MODE_RISE16) ? 17 :
				1 + r[8:6] % 5;
			kx = r[10:9];
			tmr_a = rnd();
			tmr_b = rnd();
			mask  = rnd();
			wr(icu_pkg::OFF_TMR_A, tmr_a);
			wr(icu_pkg::OFF_TMR_B, tmr_b);
			wr(icu_pkg::OFF_INT_MASK, mask);
			base = icu_pkg::OFF_CH_BASE + 8'(ch * 4);
			wr(base, {10'h000, lvl, tsel, m});
			// external clock pulses advance both timebases
			repeat (kx)
			begin
				ext_clk <= 1'b1;
				@(posedge clk);
				ext_clk <= 1'b0;
				@(posedge clk);
			end
			wakes = 0;
			src_ch <= 2'(ch);
			src_n  <= 5'(n);
			src_go <= 1'b1;
			@(posedge clk);
			src_go <= 1'b0;
			@(posedge clk);
			for (w = 0; src_busy === 1'b1 && w < 200; w++)
				@(posedge clk);
			// a burst that never ends is a mismatch
			if (w >= 200)
				fails++;
			repeat (3) @(posedge clk);
			// model of captures over the 2n pin edges, fifo depth four and overflow
			exp_q.delete();
			ovf  = 1'b0;
			ncap = 0;
			for (int e = 0; e < 2 * n; e++)
				if ((e % 2 == 0) ? (m == icu_pkg::ICU_MODE_RISE || m == icu_pkg::ICU_MODE_BOTH ||
					(m == icu_pkg::ICU_MODE_RISE4 && e % 8 == 6) ||
					(m == icu_pkg::ICU_MODE_RISE16 && e % 32 == 30)) :
					(m == icu_pkg::ICU_MODE_FALL || m == icu_pkg::ICU_MODE_BOTH))
				begin
					ncap++;
					// timebase a counts pin rises too, a capture sees the rises before it
					if (exp_q.size() < 4)
						exp_q.push_back(tsel ? tmr_b + 16'(kx) : tmr_a + 16'(kx + (e + 1) / 2));
					else
						ovf = 1'b1;
				end
			st = 16'h0000;
			st[ch] = (exp_q.size() > lvl);
			st[4 + ch] = ovf;
			st[8 + ch] = (m == icu_pkg::ICU_MODE_EXTINT);
			chk("irq", {15'h0000, irq}, {15'h0000, |(st & mask)});
			chk("wakes", 16'(wakes), (cpu_sleep | cpu_idle) ? 16'(ncap + ((m ==
				icu_pkg::ICU_MODE_EXTINT) ? n : 0)) : 16'h0000);
			rc("int status", icu_pkg::OFF_INT_STAT, st);
			chk("irq cleared", {15'h0000, irq}, 16'h0000);
			rc("chan status", base + 8'h02, 16'(exp_q.size() * 4 + ovf * 2 +
				(exp_q.size() > 0)));
			while (exp_q.size() > 0)
				rc("capture", base + 8'h01, exp_q.pop_front());
			rc("chan empty", base + 8'h02, 16'h0000);
			wr(base, 16'h0000);
		end
		print_verdict();
	end
endmodule
